// [rtl/sod_datapath.sv]
`timescale 1ns/1ps
`default_nettype none
module sod_datapath (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction
    input wire logic op_valid,
    input wire sod_pkg::sod_op_t op,
    input wire logic [sod_pkg::ADDR_W-1:0] file_addr,
    input wire logic dest,
    input wire logic [sod_pkg::DATA_W-1:0] file_rdata,
    // wake
    input wire logic ext_wake,
    // file write
    output logic file_we,
    output logic [sod_pkg::ADDR_W-1:0] file_waddr,
    output logic [sod_pkg::DATA_W-1:0] file_wdata,
    // state
    output logic [sod_pkg::DATA_W-1:0] acc,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic power_down_flag,
    output logic core_stopped
);
    import sod_pkg::*;

    // ==========================================
    // arithmetic
    logic [DATA_W-1:0] diff;
    logic no_borrow;
    logic nibble_no_borrow;
    logic is_zero;
    logic borrow_in;
    logic is_sub;

    always_comb begin
        is_sub = (op == SOD_OP_SUB) || (op == SOD_OP_SUB_BORROW);
        borrow_in = (op == SOD_OP_SUB_BORROW) ? ~carry_flag : 1'b0;
    end

    sod_subtractor #(.W(DATA_W)) u_sub (
        .minuend(file_rdata),
        .subtrahend(acc),
        .borrow_in(borrow_in),
        .diff(diff),
        .no_borrow(no_borrow),
        .nibble_no_borrow(nibble_no_borrow),
        .is_zero(is_zero)
    );

    // ==========================================
    // sequencer state
    sod_state_t state;
    sod_state_t next_state;
    logic next_power_down_flag;
    logic next_core_stopped;

    // ==========================================
    // decode of the accepted instruction
    logic running;
    logic take_sub;
    logic take_sleep;
    logic take_wake;
    logic write_acc;
    logic write_file;

    always_comb begin
        running = (state == SOD_RUN);
        take_sub = running && op_valid && is_sub;
        take_sleep = running && op_valid && (op == SOD_OP_SLEEP);
        take_wake = !running && ext_wake;
        write_acc = take_sub && (dest == DEST_ACC);
        write_file = take_sub && (dest == DEST_FILE);
    end

    // ==========================================
    // sequencer: running, or asleep until ext_wake
    always_comb begin
        next_state = state;
        next_power_down_flag = power_down_flag;
        unique case (state)
            SOD_RUN: begin
                if (take_sleep) begin
                    next_state = SOD_ASLEEP;
                    next_power_down_flag = 1'b1;
                end
            end
            SOD_ASLEEP: begin
                if (take_wake) begin
                    next_state = SOD_RUN;
                end
            end
        endcase
        next_core_stopped = (next_state == SOD_ASLEEP);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= SOD_RUN;
            power_down_flag <= POWER_DOWN_RESET;
            core_stopped <= CORE_STOPPED_RESET;
        end else begin
            state <= next_state;
            power_down_flag <= next_power_down_flag;
            core_stopped <= next_core_stopped;
        end
    end

    // ==========================================
    // accumulator
    logic [DATA_W-1:0] next_acc;

    always_comb begin
        next_acc = acc;
        if (write_acc) begin
            next_acc = diff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc <= ACC_RESET;
        end else begin
            acc <= next_acc;
        end
    end

    // ==========================================
    // carry flag, set when no borrow
    logic next_carry_flag;

    always_comb begin
        next_carry_flag = carry_flag;
        if (take_sub) begin
            next_carry_flag = no_borrow;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carry_flag <= CARRY_RESET;
        end else begin
            carry_flag <= next_carry_flag;
        end
    end

    // ==========================================
    // digit carry flag, set when the low nibble did not borrow
    logic next_digit_carry_flag;

    always_comb begin
        next_digit_carry_flag = digit_carry_flag;
        if (take_sub) begin
            next_digit_carry_flag = nibble_no_borrow;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            digit_carry_flag <= DIGIT_CARRY_RESET;
        end else begin
            digit_carry_flag <= next_digit_carry_flag;
        end
    end

    // ==========================================
    // zero flag
    logic next_zero_flag;

    always_comb begin
        next_zero_flag = zero_flag;
        if (take_sub) begin
            next_zero_flag = is_zero;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zero_flag <= ZERO_RESET;
        end else begin
            zero_flag <= next_zero_flag;
        end
    end

    // ==========================================
    // file write strobe, one cycle per write
    logic next_file_we;

    always_comb begin
        next_file_we = write_file;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_we <= FILE_WE_RESET;
        end else begin
            file_we <= next_file_we;
        end
    end

    // ==========================================
    // file write address and data, held until the next write
    logic [ADDR_W-1:0] next_file_waddr;
    logic [DATA_W-1:0] next_file_wdata;

    always_comb begin
        next_file_waddr = file_waddr;
        next_file_wdata = file_wdata;
        if (write_file) begin
            next_file_waddr = file_addr;
            next_file_wdata = diff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_waddr <= FILE_WADDR_RESET;
            file_wdata <= FILE_WDATA_RESET;
        end else begin
            file_waddr <= next_file_waddr;
            file_wdata <= next_file_wdata;
        end
    end
endmodule
`default_nettype wire

// [rtl/sod_subtractor.sv]
`timescale 1ns/1ps
`default_nettype none
module sod_subtractor #(
    parameter int W = 8
) (
    // operands
    input wire logic [W-1:0] minuend,
    input wire logic [W-1:0] subtrahend,
    input wire logic borrow_in,
    // results
    output logic [W-1:0] diff,
    output logic no_borrow,
    output logic nibble_no_borrow,
    output logic is_zero
);
    import sod_pkg::*;
    logic [W:0] full;
    logic [NIBBLE_W:0] low;
    always_comb begin
        full = {1'b0, minuend} - {1'b0, subtrahend} - {{W{1'b0}}, borrow_in};
        low = {1'b0, minuend[NIBBLE_W-1:0]} - {1'b0, subtrahend[NIBBLE_W-1:0]} - {{NIBBLE_W{1'b0}}, borrow_in};
        diff = full[W-1:0];
        no_borrow = ~full[W];
        nibble_no_borrow = ~low[NIBBLE_W];
        is_zero = (full[W-1:0] == '0);
    end
endmodule
`default_nettype wire

// [shared/sod_pkg.sv]
`default_nettype none
package sod_pkg;
    // ==========================================
    // widths and addressing
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] FILE_ADDR_MAX = 8'hff;
    localparam int NIBBLE_W = 4;
    // ==========================================
    // destination field
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    // ==========================================
    // reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic CARRY_RESET = 1'b0;
    localparam logic DIGIT_CARRY_RESET = 1'b0;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic POWER_DOWN_RESET = 1'b0;
    localparam logic CORE_STOPPED_RESET = 1'b0;
    localparam logic FILE_WE_RESET = 1'b0;
    localparam logic [ADDR_W-1:0] FILE_WADDR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] FILE_WDATA_RESET = 8'h00;
    // ==========================================
    // operations
    typedef enum logic [1:0] {
        SOD_OP_NONE,
        SOD_OP_SUB,
        SOD_OP_SUB_BORROW,
        SOD_OP_SLEEP
    } sod_op_t;
    typedef enum logic {
        SOD_RUN,
        SOD_ASLEEP
    } sod_state_t;
endpackage
`default_nettype wire

// [sim/sod_datapath_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sod_datapath_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction
    input wire logic op_valid,
    input wire sod_pkg::sod_op_t op,
    input wire logic [sod_pkg::ADDR_W-1:0] file_addr,
    input wire logic dest,
    input wire logic [sod_pkg::DATA_W-1:0] file_rdata,
    input wire logic ext_wake,
    // watched outputs
    input wire logic file_we,
    input wire logic [sod_pkg::ADDR_W-1:0] file_waddr,
    input wire logic [sod_pkg::DATA_W-1:0] file_wdata,
    input wire logic [sod_pkg::DATA_W-1:0] acc,
    input wire logic carry_flag,
    input wire logic digit_carry_flag,
    input wire logic zero_flag,
    input wire logic power_down_flag,
    input wire logic core_stopped
);
    import sod_pkg::*;
    wire logic sb = op_valid && !core_stopped && (op inside {SOD_OP_SUB, SOD_OP_SUB_BORROW});
    wire logic bi = (op == SOD_OP_SUB_BORROW) && !carry_flag;
    wire logic [8:0] d = {1'b0, file_rdata} - {1'b0, acc} - {8'h00, bi};
    wire logic [7:0] res = d[7:0];
    wire logic nb = !d[8];
    wire logic nib_ok = file_rdata[3:0] >= ({1'b0, acc[3:0]} + {4'h0, bi});
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence seq_sleep_taken;
        op_valid && !core_stopped && (op == SOD_OP_SLEEP);
    endsequence
    sequence seq_stopped_down;
        core_stopped && power_down_flag;
    endsequence
    AST_ACC: assert property (sb && !dest |=> acc == $past(res)) else $error("acc");
    AST_DST: assert property (sb && dest |=> file_we && file_wdata == $past(res)
        && acc == $past(acc)) else $error("dest");
    AST_FLG: assert property (sb |=> carry_flag == $past(nb)
        && zero_flag == ($past(res) == 8'h00)) else $error("flags");
    AST_DIGIT: assert property (sb |=> digit_carry_flag == $past(nib_ok))
        else $error("digit carry");
    AST_SLP: assert property (seq_sleep_taken |=> seq_stopped_down) else $error("sleep");
    AST_WAKE: assert property (core_stopped && ext_wake |=> !core_stopped) else $error("wake");
    AST_IGN: assert property (core_stopped && !ext_wake |=> core_stopped && !file_we
        && $stable(acc) && $stable(carry_flag) && $stable(zero_flag)) else $error("ign");
    AST_WADDR: assert property (sb && dest |=> file_waddr == $past(file_addr)) else $error("waddr");
    AST_NO_WRITE: assert property (!(sb && dest) |=> !file_we) else $error("no write");
    AST_PD_HOLD: assert property (power_down_flag |=> power_down_flag) else $error("pd hold");
endmodule
bind sod_datapath sod_datapath_chk u_chk (
    .clk(clk),
    .rst(rst),
    .op_valid(op_valid),
    .op(op),
    .file_addr(file_addr),
    .dest(dest),
    .file_rdata(file_rdata),
    .ext_wake(ext_wake),
    .file_we(file_we),
    .file_waddr(file_waddr),
    .file_wdata(file_wdata),
    .acc(acc),
    .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag),
    .zero_flag(zero_flag),
    .power_down_flag(power_down_flag),
    .core_stopped(core_stopped)
);
`default_nettype wire

// [sim/tb_sod_datapath.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sod_datapath;
    import sod_pkg::*;
    logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, dest = 1'b0, ext_wake = 1'b0, ms = 1'b0, mp = 1'b0;
    logic file_we, carry_flag, digit_carry_flag, zero_flag, power_down_flag, core_stopped;
    logic [7:0] file_addr = 8'h00, file_rdata = 8'h00, ma = 8'h00, mw = 8'h00, md = 8'h00;
    logic [7:0] file_waddr, file_wdata, acc;
    logic [2:0] mf = 3'h0;
    logic [31:0] lf = 32'h9ef3423b;
    int miscompares = 0, checks = 0, cyc = 0;
    sod_op_t op = SOD_OP_NONE;
    sod_datapath u_dut (
        .clk(clk),
        .rst(rst),
        .op_valid(op_valid),
        .op(op),
        .file_addr(file_addr),
        .dest(dest),
        .file_rdata(file_rdata),
        .ext_wake(ext_wake),
        .file_we(file_we),
        .file_waddr(file_waddr),
        .file_wdata(file_wdata),
        .acc(acc),
        .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag),
        .power_down_flag(power_down_flag),
        .core_stopped(core_stopped)
    );
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (++cyc == 400) begin
        miscompares++;
        print_verdict();
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // {no borrow, no nibble borrow, zero, result} of file minus acc minus borrow
    function automatic logic [10:0] sub_model(input logic [7:0] f, input logic [7:0] a, input logic b);
        logic [8:0] r;
        r = {1'b0, f} - {1'b0, a} - {8'h00, b};
        return {!r[8], f[3:0] >= ({1'b0, a[3:0]} + {4'h0, b}), r[7:0] == 8'h00, r[7:0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic run(input sod_op_t o, input logic [7:0] f, input logic d);
        logic b;
        logic s;
        logic [10:0] e;
        b = (o == SOD_OP_SUB_BORROW) && !mf[2];
        s = !ms && (o inside {SOD_OP_SUB, SOD_OP_SUB_BORROW});
        e = sub_model(f, ma, b);
        op <= o;
        {file_rdata, file_addr, dest, op_valid} <= {f, ~f, d, 1'b1};
        ms = ms | (o == SOD_OP_SLEEP);
        mp = mp | ms;
        if (s) begin
            mf = e[10:8];
            if (d) begin
                mw = ~f;
                md = e[7:0];
            end else begin
                ma = e[7:0];
            end
        end
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("acc", acc, ma);
        chk("ctl", {file_we, core_stopped, power_down_flag}, {s & d, ms, mp});
        chk("wdata", file_wdata, md);
        chk("waddr", file_waddr, mw);
        chk("flg", {carry_flag, digit_carry_flag, zero_flag}, mf);
        @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        run(SOD_OP_SUB, 8'h33, 0);
        run(SOD_OP_SUB, 8'h32, 1);
        run(SOD_OP_SUB_BORROW, 8'h34, 1);
        run(SOD_OP_SUB_BORROW, 8'h33, 0);
        run(SOD_OP_NONE, 8'h55, 1);
        repeat (40) begin
            lf = lfsr(lf);
            run(sod_op_t'({1'b0, lf[0]} + {1'b0, lf[1]}), lf[15:8], lf[2]);
        end
        $display("subtract test done");
        ext_wake <= 1'b0;
        run(SOD_OP_SLEEP, 8'h00, 0);
        run(SOD_OP_NONE, 8'h00, 0);
        run(SOD_OP_SUB, 8'h77, 1);
        ext_wake <= 1'b1;
        @(posedge clk);
        ext_wake <= 1'b0;
        ms = 1'b0;
        run(SOD_OP_SUB_BORROW, 8'h77, 0);
        $display("sleep test done");
        run(SOD_OP_SLEEP, 8'h00, 0);
        run(SOD_OP_NONE, 8'h00, 0);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst_acc", acc, ACC_RESET);
        chk("rst_ctl", {file_we, core_stopped, power_down_flag}, {FILE_WE_RESET, CORE_STOPPED_RESET, POWER_DOWN_RESET});
        chk("rst_flg", {carry_flag, digit_carry_flag, zero_flag}, {CARRY_RESET, DIGIT_CARRY_RESET, ZERO_RESET});
        chk("rst_waddr", file_waddr, FILE_WADDR_RESET);
        chk("rst_wdata", file_wdata, FILE_WDATA_RESET);
        @(posedge clk);
        rst <= 1'b0;
        ma = ACC_RESET;
        mf = {CARRY_RESET, DIGIT_CARRY_RESET, ZERO_RESET};
        ms = CORE_STOPPED_RESET;
        mp = POWER_DOWN_RESET;
        mw = FILE_WADDR_RESET;
        md = FILE_WDATA_RESET;
        run(SOD_OP_SUB_BORROW, 8'h10, 1);
        run(SOD_OP_SUB, 8'h00, 0);
        $display("reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
